// *** hw/bit_shift_flag_ops_unit.sv ***
// Implementation choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - io clear-bit zeroes one bit of an I/O register, no flags, two cycles
// - io set-bit sets one bit of an I/O register, no flags, two cycles
// - left shift: bits up, zero into bit 0, updates Z C N V, one cycle
// - right shift: bits down, zero into bit 7, updates Z C N V, one cycle
// - rotate left: carry into bit 0, bit 7 to carry, Z C N V, one cycle
// - rotate right: carry into bit 7, bit 0 to carry, Z C N V, one cycle
// - arithmetic right shift keeps bit 7, updates Z C N V, one cycle
// - nibble swap exchanges halves, one cycle, flags unchanged
// - bit store copies selected bit into transfer flag only, one cycle
// - bit load copies transfer flag into selected bit, flags unchanged
// - interrupt enable sets the global enable flag only, one cycle
// - interrupt disable clears the global enable flag only, one cycle
// - half-carry set and clear touch only that flag, one cycle
// - overflow set and clear touch only that flag, one cycle
// - signed test clear touches only that flag, one cycle
// - sleep takes three cycles, no flags, signals sleep logic
// - watchdog restart takes one cycle, no flags, pulses the watchdog
module bit_shift_flag_ops_unit
  import bit_shift_flag_pkg::*;
#(
  parameter int IO_DEPTH = 8
) (
  input  wire logic      clk,
  input  wire logic      reset_n,
  input  wire logic      req_valid,
  input  wire exec_req_t req,
  output logic           req_ready,
  output logic           done,
  output logic           result_we,
  output logic [7:0]     result,
  output logic [7:0]     status_flags_register,
  output logic           sleep_enter,
  output logic           watchdog_restart,
  input  wire reg_req_t  bus,
  output logic [7:0]     bus_rdata
);
  // ==========================================================
  // helpers
  function automatic logic [1:0] op_cycles(input op_t op);
    case (op)
      io_bit_clear_op, io_bit_set_op: op_cycles = CYC_IO;
      sleep_op:                       op_cycles = CYC_SLEEP;
      default:                        op_cycles = CYC_ONE;
    endcase
  endfunction

  // returns {carry, value}
  function automatic logic [8:0] shift_calc(input op_t op, input logic [7:0] d, input logic c);
    case (op)
      logical_left_shift_op:  shift_calc = {d[7], d[6:0], 1'b0};
      logical_right_shift_op: shift_calc = {d[0], 1'b0, d[7:1]};
      rotate_left_carry_op:   shift_calc = {d[7], d[6:0], c};
      rotate_right_carry_op:  shift_calc = {d[0], c, d[7:1]};
      arith_right_shift_op:   shift_calc = {d[0], d[7], d[7:1]};
      default:                shift_calc = {c, d};
    endcase
  endfunction

  // returns {hit, value, index}
  function automatic logic [4:0] flag_calc(input op_t op, input logic [2:0] sel);
    case (op)
      generic_flag_set_op:   flag_calc = {2'b11, sel};
      generic_flag_clear_op: flag_calc = {2'b10, sel};
      irq_enable_op:         flag_calc = {2'b11, FLAG_I};
      irq_disable_op:        flag_calc = {2'b10, FLAG_I};
      half_carry_set_op:     flag_calc = {2'b11, FLAG_H};
      half_carry_clear_op:   flag_calc = {2'b10, FLAG_H};
      overflow_set_op:       flag_calc = {2'b11, FLAG_V};
      overflow_clear_op:     flag_calc = {2'b10, FLAG_V};
      signed_test_clear_op:  flag_calc = {2'b10, FLAG_S};
      carry_set_op:          flag_calc = {2'b11, FLAG_C};
      carry_clear_op:        flag_calc = {2'b10, FLAG_C};
      negative_set_op:       flag_calc = {2'b11, FLAG_N};
      negative_clear_op:     flag_calc = {2'b10, FLAG_N};
      zero_set_op:           flag_calc = {2'b11, FLAG_Z};
      zero_clear_op:         flag_calc = {2'b10, FLAG_Z};
      transfer_set_op:       flag_calc = {2'b11, FLAG_T};
      transfer_clear_op:     flag_calc = {2'b10, FLAG_T};
      default:               flag_calc = 5'h00;
    endcase
  endfunction

  function automatic logic is_shift(input op_t op);
    is_shift = (op == logical_left_shift_op) || (op == logical_right_shift_op) ||
               (op == rotate_left_carry_op) || (op == rotate_right_carry_op) ||
               (op == arith_right_shift_op);
  endfunction

  // ==========================================================
  // issue and cycle count
  logic [1:0]            cycles_left;
  logic                  take;
  logic [8:0]            shifted;
  logic [4:0]            flag_hit;
  logic                  io_ok;
  logic                  bus_io_hit;
  logic [IO_INDEX_W-1:0] bus_io_index;
  logic [7:0]            io_regs [IO_DEPTH];

  assign req_ready = (cycles_left == 2'h0);
  assign take      = req_valid && req_ready;
  assign shifted   = shift_calc(req.op, req.operand, status_flags_register[FLAG_C]);
  assign flag_hit  = flag_calc(req.op, req.bit_sel);
  assign io_ok     = 32'(req.io_index) < IO_DEPTH;
  assign bus_io_hit   = bus.addr >= REG_IO_BASE && 32'(bus.addr - REG_IO_BASE) < IO_DEPTH;
  assign bus_io_index = IO_INDEX_W'(bus.addr - REG_IO_BASE);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cycles_left <= 2'h0;
    end else if (take) begin
      cycles_left <= op_cycles(req.op) - 2'h1;
    end else if (cycles_left != 2'h0) begin
      cycles_left <= cycles_left - 2'h1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      done <= 1'b0;
    end else begin
      done <= (take && op_cycles(req.op) == CYC_ONE) || (cycles_left == 2'h1);
    end
  end

  // ==========================================================
  // status flags
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      status_flags_register <= STATUS_RESET;
    end else if (take && is_shift(req.op)) begin
      status_flags_register[FLAG_C] <= shifted[8];
      status_flags_register[FLAG_Z] <= shifted[7:0] == 8'h00;
      status_flags_register[FLAG_N] <= shifted[7];
      status_flags_register[FLAG_V] <= shifted[7] ^ shifted[8];
    end else if (take && req.op == bit_to_transfer_flag_op) begin
      status_flags_register[FLAG_T] <= req.operand[req.bit_sel];
    end else if (take && flag_hit[4]) begin
      status_flags_register[flag_hit[2:0]] <= flag_hit[3];
    end else if (bus.wr && bus.addr == REG_STATUS) begin
      status_flags_register <= bus.wdata;
    end
  end

  // ==========================================================
  // register result
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      result_we <= 1'b0;
      result    <= 8'h00;
    end else begin
      result_we <= take && (is_shift(req.op) || req.op == nibble_swap_op ||
                            req.op == transfer_flag_to_bit_op);
      if (take && is_shift(req.op)) begin
        result <= shifted[7:0];
      end else if (take && req.op == nibble_swap_op) begin
        result <= {req.operand[3:0], req.operand[7:4]};
      end else if (take && req.op == transfer_flag_to_bit_op) begin
        result                <= req.operand;
        result[req.bit_sel]   <= status_flags_register[FLAG_T];
      end
    end
  end

  // ==========================================================
  // I/O registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < IO_DEPTH; i++) begin
        io_regs[i] <= IO_RESET;
      end
    end else begin
      for (int i = 0; i < IO_DEPTH; i++) begin
        if (take && io_ok && req.io_index == IO_INDEX_W'(i) && req.op == io_bit_clear_op) begin
          io_regs[i][req.bit_sel] <= 1'b0;
        end else if (take && io_ok && req.io_index == IO_INDEX_W'(i) && req.op == io_bit_set_op) begin
          io_regs[i][req.bit_sel] <= 1'b1;
        end else if (bus.wr && bus_io_hit && bus_io_index == IO_INDEX_W'(i)) begin
          io_regs[i] <= bus.wdata;
        end
      end
    end
  end

  // ==========================================================
  // sleep and watchdog pulses
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sleep_enter      <= 1'b0;
      watchdog_restart <= 1'b0;
    end else begin
      sleep_enter      <= take && req.op == sleep_op;
      watchdog_restart <= take && req.op == watchdog_restart_op;
    end
  end

  // ==========================================================
  // register read
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bus_rdata <= 8'h00;
    end else if (!bus.rd) begin
      bus_rdata <= 8'h00;
    end else if (bus.addr == REG_STATUS) begin
      bus_rdata <= status_flags_register;
    end else if (bus.addr == REG_RESULT) begin
      bus_rdata <= result;
    end else if (bus.addr == REG_STATE) begin
      bus_rdata <= {5'h00, !req_ready, cycles_left};
    end else if (bus_io_hit) begin
      bus_rdata <= io_regs[bus_io_index];
    end else begin
      bus_rdata <= 8'h00;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_take(op_t o);
    req_valid && req_ready && req.op == o;
  endsequence
  sequence s_one_busy;
    !req_ready ##1 req_ready;
  endsequence
  sequence s_two_busy;
    !req_ready [*2] ##1 req_ready;
  endsequence

  a_io_clear_bit: assert property (s_take(io_bit_clear_op) ##0 io_ok |=>
    io_regs[$past(req.io_index)] == ($past(io_regs[req.io_index]) & ~(8'h01 << $past(req.bit_sel)))
    && $stable(status_flags_register) ##0 s_one_busy) else $error("io clear bit wrong");
  a_io_set_bit: assert property (s_take(io_bit_set_op) ##0 io_ok |=>
    io_regs[$past(req.io_index)] == ($past(io_regs[req.io_index]) | (8'h01 << $past(req.bit_sel)))
    && $stable(status_flags_register) ##0 s_one_busy) else $error("io set bit wrong");
  a_left_shift: assert property (s_take(logical_left_shift_op) |=>
    result == {$past(req.operand[6:0]), 1'b0} && status_flags_register[FLAG_C] == $past(req.operand[7])
    && req_ready && done) else $error("left shift wrong");
  a_right_shift: assert property (s_take(logical_right_shift_op) |=>
    result == {1'b0, $past(req.operand[7:1])} && status_flags_register[FLAG_C] == $past(req.operand[0])
    && status_flags_register[FLAG_N] == 1'b0) else $error("right shift wrong");
  a_rotate_left: assert property (s_take(rotate_left_carry_op) |=>
    result == {$past(req.operand[6:0]), $past(status_flags_register[FLAG_C])}
    && status_flags_register[FLAG_C] == $past(req.operand[7])) else $error("rotate left wrong");
  a_rotate_right: assert property (s_take(rotate_right_carry_op) |=>
    result == {$past(status_flags_register[FLAG_C]), $past(req.operand[7:1])}
    && status_flags_register[FLAG_Z] == (result == 8'h00)) else $error("rotate right wrong");
  a_arith_shift: assert property (s_take(arith_right_shift_op) |=>
    result == {$past(req.operand[7]), $past(req.operand[7:1])} && status_flags_register[FLAG_V] ==
    (status_flags_register[FLAG_N] ^ status_flags_register[FLAG_C])) else $error("arith shift wrong");
  a_nibble_swap: assert property (s_take(nibble_swap_op) |=>
    result == {$past(req.operand[3:0]), $past(req.operand[7:4])} && result_we
    && $stable(status_flags_register)) else $error("nibble swap wrong");
  a_bit_store: assert property (s_take(bit_to_transfer_flag_op) |=>
    status_flags_register == (($past(status_flags_register) & 8'hbf) |
    {1'b0, $past(req.operand[req.bit_sel]), 6'h00})) else $error("bit store wrong");
  a_bit_load: assert property (s_take(transfer_flag_to_bit_op) |=>
    result[$past(req.bit_sel)] == $past(status_flags_register[FLAG_T])
    && $stable(status_flags_register)) else $error("bit load wrong");
  a_irq_enable: assert property (s_take(irq_enable_op) |=>
    status_flags_register == ($past(status_flags_register) | 8'h80)) else $error("irq enable wrong");
  a_irq_disable: assert property (s_take(irq_disable_op) |=>
    status_flags_register == ($past(status_flags_register) & 8'h7f)) else $error("irq disable wrong");
  a_half_overflow_sign: assert property (
    s_take(half_carry_set_op) or s_take(overflow_clear_op) or s_take(signed_test_clear_op) |=>
    status_flags_register == (($past(req.op) == half_carry_set_op) ? ($past(status_flags_register) | 8'h20) :
    ($past(req.op) == overflow_clear_op) ? ($past(status_flags_register) & 8'hf7) :
    ($past(status_flags_register) & 8'hef)) && req_ready)
    else $error("single flag op wrong");
  a_sleep_span: assert property (s_take(sleep_op) |=> sleep_enter
    && $stable(status_flags_register) ##0 s_two_busy ##0 done) else $error("sleep span wrong");
  a_watchdog_pulse: assert property (s_take(watchdog_restart_op) |=>
    watchdog_restart && req_ready && $stable(status_flags_register)
    ##1 watchdog_restart == ($past(take) && $past(req.op) == watchdog_restart_op))
    else $error("watchdog pulse wrong");
  a_nop_quiet: assert property (s_take(nop_op) ##0 !bus.wr |=>
    $stable(status_flags_register) && !result_we && done) else $error("nop changed state");
  a_half_clear: assert property (s_take(half_carry_clear_op) |=>
    status_flags_register == ($past(status_flags_register) & ~(8'h01 << FLAG_H)))
    else $error("half carry clear wrong");
  a_overflow_set: assert property (s_take(overflow_set_op) |=>
    status_flags_register == ($past(status_flags_register) | (8'h01 << FLAG_V)))
    else $error("overflow set wrong");
  a_generic_set: assert property (s_take(generic_flag_set_op) |=>
    status_flags_register == ($past(status_flags_register) | (8'h01 << $past(req.bit_sel))))
    else $error("generic flag set wrong");
  a_generic_clear: assert property (s_take(generic_flag_clear_op) |=>
    status_flags_register == ($past(status_flags_register) & ~(8'h01 << $past(req.bit_sel))))
    else $error("generic flag clear wrong");
  a_transfer_set: assert property (s_take(transfer_set_op) |=>
    status_flags_register == ($past(status_flags_register) | (8'h01 << FLAG_T)))
    else $error("transfer flag set wrong");
  a_carry_clear: assert property (s_take(carry_clear_op) |=>
    status_flags_register == ($past(status_flags_register) & ~(8'h01 << FLAG_C)))
    else $error("carry clear wrong");
  a_negative_set: assert property (s_take(negative_set_op) |=>
    status_flags_register == ($past(status_flags_register) | (8'h01 << FLAG_N)))
    else $error("negative set wrong");
  a_busy_refuses: assert property (!req_ready |=>
    !result_we && !sleep_enter && !watchdog_restart)
    else $error("request taken while busy");
  a_rdata_idle: assert property (!bus.rd |=>
    bus_rdata == 8'h00)
    else $error("read data outside read cycle");
endmodule
`default_nettype wire

// *** hw/bit_shift_flag_pkg.sv ***
`default_nettype none
package bit_shift_flag_pkg;
  // ==========================================================
  // status flag positions
  localparam logic [2:0] FLAG_C = 3'h0;
  localparam logic [2:0] FLAG_Z = 3'h1;
  localparam logic [2:0] FLAG_N = 3'h2;
  localparam logic [2:0] FLAG_V = 3'h3;
  localparam logic [2:0] FLAG_S = 3'h4;
  localparam logic [2:0] FLAG_H = 3'h5;
  localparam logic [2:0] FLAG_T = 3'h6;
  localparam logic [2:0] FLAG_I = 3'h7;
  // ==========================================================
  // cycle counts
  localparam logic [1:0] CYC_ONE   = 2'h1;
  localparam logic [1:0] CYC_IO    = 2'h2;
  localparam logic [1:0] CYC_SLEEP = 2'h3;
  // ==========================================================
  // register map and reset values
  localparam int         IO_INDEX_W   = 3;
  localparam logic [4:0] REG_STATUS   = 5'h00;
  localparam logic [4:0] REG_RESULT   = 5'h01;
  localparam logic [4:0] REG_STATE    = 5'h02;
  localparam logic [4:0] REG_IO_BASE  = 5'h10;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] IO_RESET     = 8'h00;
  // ==========================================================
  // operations
  typedef enum logic [4:0] {
    nop_op                  = 5'h00,
    io_bit_clear_op         = 5'h01,
    io_bit_set_op           = 5'h02,
    logical_left_shift_op   = 5'h03,
    logical_right_shift_op  = 5'h04,
    rotate_left_carry_op    = 5'h05,
    rotate_right_carry_op   = 5'h06,
    arith_right_shift_op    = 5'h07,
    nibble_swap_op          = 5'h08,
    generic_flag_set_op     = 5'h09,
    generic_flag_clear_op   = 5'h0a,
    bit_to_transfer_flag_op = 5'h0b,
    transfer_flag_to_bit_op = 5'h0c,
    irq_enable_op           = 5'h0d,
    irq_disable_op          = 5'h0e,
    half_carry_set_op       = 5'h0f,
    half_carry_clear_op     = 5'h10,
    overflow_set_op         = 5'h11,
    overflow_clear_op       = 5'h12,
    signed_test_clear_op    = 5'h13,
    carry_set_op            = 5'h14,
    carry_clear_op          = 5'h15,
    negative_set_op         = 5'h16,
    negative_clear_op       = 5'h17,
    zero_set_op             = 5'h18,
    zero_clear_op           = 5'h19,
    transfer_set_op         = 5'h1a,
    transfer_clear_op       = 5'h1b,
    sleep_op                = 5'h1c,
    watchdog_restart_op     = 5'h1d
  } op_t;
  typedef struct packed {
    op_t                   op;
    logic [7:0]            operand;
    logic [2:0]            bit_sel;
    logic [IO_INDEX_W-1:0] io_index;
  } exec_req_t;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [4:0] addr;
    logic [7:0] wdata;
  } reg_req_t;
endpackage
`default_nettype wire

// *** tb/bit_shift_flag_ops_unit_bench.sv ***
`timescale 1ns/1ns
`default_nettype none
module bit_shift_flag_ops_unit_bench;
  import bit_shift_flag_pkg::*;
  // ==========================================================
  // signals and model state
  logic       clk;
  logic       reset_n;
  logic       req_valid;
  exec_req_t  req;
  logic       req_ready;
  logic       done;
  logic       result_we;
  logic [7:0] result;
  logic [7:0] status_flags_register;
  logic       sleep_enter;
  logic       watchdog_restart;
  reg_req_t   bus;
  logic [7:0] bus_rdata;
  logic [7:0] mf;
  logic [7:0] mres;
  logic [7:0] mio [8];
  int         fails;
  int         n_compared;
  int         cycles;

  bit_shift_flag_ops_unit #(.IO_DEPTH(8)) DUT (
    .clk                   (clk),
    .reset_n               (reset_n),
    .req_valid             (req_valid),
    .req                   (req),
    .req_ready             (req_ready),
    .done                  (done),
    .result_we             (result_we),
    .result                (result),
    .status_flags_register (status_flags_register),
    .sleep_enter           (sleep_enter),
    .watchdog_restart      (watchdog_restart),
    .bus                   (bus),
    .bus_rdata             (bus_rdata)
  );

  always #50 clk = ~clk;

  // ==========================================================
  // checking and closing
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask

  task automatic results();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      fails++;
      results();
    end
  end

  // ==========================================================
  // register port
  function automatic logic [7:0] exp_reg(input logic [4:0] a);
    if (a == REG_STATUS) return mf;
    if (a == REG_RESULT) return mres;
    if (a >= REG_IO_BASE && a < REG_IO_BASE + 5'h08) return mio[a[2:0]];
    return 8'h00;
  endfunction

  task automatic bus_wr(input logic [4:0] a, input logic [7:0] d);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    bus <= '0;
    if (a == REG_STATUS) mf = d;
    else if (a >= REG_IO_BASE && a < REG_IO_BASE + 5'h08) mio[a[2:0]] = d;
    @(posedge clk);
  endtask

  task automatic bus_rd(input logic [4:0] a);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    bus <= '0;
    @(negedge clk);
    chk("bus_rdata", bus_rdata, exp_reg(a));
    @(negedge clk);
    chk("bus_rdata idle", bus_rdata, 8'h00);
    @(posedge clk);
  endtask

  // ==========================================================
  // execution port with model
  task automatic exec(input op_t op, input logic [7:0] a, input logic [2:0] b, input logic [2:0] idx);
    logic [7:0] r;
    logic [7:0] f;
    logic       c;
    logic       we;
    logic       slp;
    logic       wd;
    logic [1:0] cyc;
    r = mres;
    c = 1'b0;
    slp = 1'b0;
    wd = 1'b0;
    cyc = CYC_ONE;
    req_valid <= 1'b1;
    req <= '{op: op, operand: a, bit_sel: b, io_index: idx};
    @(posedge clk);
    case (op)
      io_bit_clear_op, io_bit_set_op: begin
        mio[idx][b] = (op == io_bit_set_op);
        cyc = CYC_IO;
      end
      logical_left_shift_op:   {c, r} = {a, 1'b0};
      logical_right_shift_op:  {r, c} = {1'b0, a};
      rotate_left_carry_op:    {c, r} = {a, mf[FLAG_C]};
      rotate_right_carry_op:   {r, c} = {mf[FLAG_C], a};
      arith_right_shift_op:    {r, c} = {a[7], a};
      nibble_swap_op:          r = {a[3:0], a[7:4]};
      generic_flag_set_op:     mf[b] = 1'b1;
      generic_flag_clear_op:   mf[b] = 1'b0;
      bit_to_transfer_flag_op: mf[FLAG_T] = a[b];
      transfer_flag_to_bit_op: r = (a & ~(8'h01 << b)) | (8'(mf[FLAG_T]) << b);
      irq_enable_op:           mf[FLAG_I] = 1'b1;
      irq_disable_op:          mf[FLAG_I] = 1'b0;
      half_carry_set_op:       mf[FLAG_H] = 1'b1;
      half_carry_clear_op:     mf[FLAG_H] = 1'b0;
      overflow_set_op:         mf[FLAG_V] = 1'b1;
      overflow_clear_op:       mf[FLAG_V] = 1'b0;
      signed_test_clear_op:    mf[FLAG_S] = 1'b0;
      carry_set_op:            mf[FLAG_C] = 1'b1;
      carry_clear_op:          mf[FLAG_C] = 1'b0;
      negative_set_op:         mf[FLAG_N] = 1'b1;
      negative_clear_op:       mf[FLAG_N] = 1'b0;
      zero_set_op:             mf[FLAG_Z] = 1'b1;
      zero_clear_op:           mf[FLAG_Z] = 1'b0;
      transfer_set_op:         mf[FLAG_T] = 1'b1;
      transfer_clear_op:       mf[FLAG_T] = 1'b0;
      sleep_op: begin
        cyc = CYC_SLEEP;
        slp = 1'b1;
      end
      watchdog_restart_op:     wd = 1'b1;
      default: ;
    endcase
    we = op inside {logical_left_shift_op, logical_right_shift_op, rotate_left_carry_op,
                    rotate_right_carry_op, arith_right_shift_op, nibble_swap_op, transfer_flag_to_bit_op};
    if (we && op != nibble_swap_op && op != transfer_flag_to_bit_op) begin
      mf[FLAG_C] = c;
      mf[FLAG_Z] = (r == 8'h00);
      mf[FLAG_N] = r[7];
      mf[FLAG_V] = r[7] ^ c;
    end
    if (we) mres = r;
    r = mres;
    f = mf;
    if (cyc != CYC_ONE) req_valid <= 1'b0;
    fork
      begin
        for (int k = 1; k <= cyc; k++) begin
          @(negedge clk);
          chk("done", 8'(done), 8'(k == cyc));
          chk("req_ready", 8'(req_ready), 8'(k == cyc));
          if (k == 1) begin
            chk("flags", status_flags_register, f);
            chk("result_we", 8'(result_we), 8'(we));
            chk("result", result, r);
            chk("sleep_enter", 8'(sleep_enter), 8'(slp));
            chk("watchdog_restart", 8'(watchdog_restart), 8'(wd));
          end
        end
      end
    join_none
    if (cyc != CYC_ONE) repeat (cyc - 1) @(posedge clk);
  endtask

  task automatic idle();
    req_valid <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    req_valid = 1'b0;
    req = '0;
    bus = '0;
    mf = STATUS_RESET;
    mres = 8'h00;
    for (int i = 0; i < 8; i++) mio[i] = IO_RESET;
    void'($urandom(54));
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    for (int a = 0; a < 32; a++) bus_rd(5'(a));
    for (int a = 0; a < 32; a++) bus_wr(5'(a), 8'($urandom));
    for (int a = 0; a < 32; a++) bus_rd(5'(a));
    exec(logical_left_shift_op, 8'h81, 3'h0, 3'h0);
    fork
      exec(io_bit_set_op, 8'h00, 3'h2, 3'h1);
      bus_wr(REG_IO_BASE + 5'h05, 8'h5a);
    join
    bus_rd(REG_IO_BASE + 5'h01);
    bus_rd(REG_IO_BASE + 5'h05);
    for (int o = 0; o < 30; o++) exec(op_t'(5'(o)), 8'($urandom), 3'($urandom), 3'($urandom));
    repeat (400) exec(op_t'(5'($urandom_range(0, 29))), 8'($urandom), 3'($urandom), 3'($urandom));
    idle();
    for (int a = 0; a < 32; a++) bus_rd(5'(a));
    results();
  end
endmodule
`default_nettype wire
